/* File: design/srcm_regs.svh */
// timing counts and register offsets for the relay contact monitor
`ifndef SRCM_REGS_SVH
`define SRCM_REGS_SVH
`define SRCM_CLK_MHZ 250
`define SRCM_MISMATCH_US 50000
`define SRCM_MISMATCH_CYC (`SRCM_MISMATCH_US * `SRCM_CLK_MHZ)
`define SRCM_CTRL_CYCLE_NS 125000
`define SRCM_CTRL_CYCLE_CYC (`SRCM_CTRL_CYCLE_NS / 4)
`define SRCM_INPUT_NS 250000
`define SRCM_INPUT_CYC (`SRCM_INPUT_NS / 4)
`define SRCM_RELEASE_NS 15000000
`define SRCM_RELEASE_CYC (`SRCM_RELEASE_NS / 4)
`define SRCM_SETTLE_CYC 16
`define SRCM_REG_CTRL 4'h0
`define SRCM_REG_STAT 4'h4
`define SRCM_REG_IRQ_STAT 4'h8
`define SRCM_REG_IRQ_CLR 4'hc
`define SRCM_REG_IRQ_EN 4'h4
`define SRCM_CTRL_TEST_BIT 0
`define SRCM_CTRL_CLR_BIT 1
`define SRCM_CTRL_EN_BIT 2
`define SRCM_CTRL_ESTOP_BIT 3
`define SRCM_CTRL_CAT1_BIT 4
`define SRCM_EV_DEFECT 0
`define SRCM_EV_FAULT 1
`define SRCM_EV_PASS 2
`define SRCM_EV_WIDTH 3
`endif

/* File: design/srcm_pkg.sv */
// types for the relay contact monitor: drive end error codes and fieldbus end release test states
package srcm_pkg;
	typedef enum logic [1:0] {
		SRCM_ERR_NONE,
		SRCM_ERR_MISMATCH,
		SRCM_ERR_ENABLE
	} srcm_err_e;
	typedef enum logic [2:0] {
		SRCM_T_IDLE,
		SRCM_T_BOTH_OFF,
		SRCM_T_FIRST_ON,
		SRCM_T_SECOND_ON,
		SRCM_T_DONE
	} srcm_test_e;
endpackage : srcm_pkg

/* File: design/srcm_if.sv */
// link between the drive monitor and the fieldbus supervisor
`timescale 1ns/1ps
interface srcm_if;
	logic relay_first_supply;
	logic relay_second_supply;
	logic ctrl_enable;
	logic fault_clear;
	logic aux_contact_first;
	logic aux_contact_second;
	logic drive_fault;
	logic [1:0] drive_err;
	logic motor_moved;
	logic contactor_open;
	modport drive (
		input relay_first_supply, relay_second_supply, ctrl_enable,
		input fault_clear,
		output aux_contact_first, aux_contact_second, drive_fault,
		output drive_err, motor_moved, contactor_open
	);
	modport fieldbus (
		output relay_first_supply, relay_second_supply, ctrl_enable,
		output fault_clear,
		input aux_contact_first, aux_contact_second, drive_fault,
		input drive_err, motor_moved, contactor_open
	);
endinterface : srcm_if

/* File: design/srcm_drive.sv */
// drive end: relay contact monitor with pulse-inhibit channels
//
// Contract
// - tolerate contact mismatch up to 50 ms
// - persistent mismatch disables controller, flags error
// - error when enabled without relay activated
// - two channels inhibit upper and lower pulses
// - expose both relay states to software
// - supervisor opens contactor on bad combination
// - supervisor runs three-step release test
// - supervisor checks contact plausibility during test
// - motion or implausibility declares safety defect
// - faults drop energy via non-safe outputs
// - relays de-energise within 15 ms
// - contact input stage adds at most 0.25 ms
// - fault reaction within one 8 kHz cycle
// - fieldbus transfer and processing within 1+1 ms
// - contactor output switches within 0.2 ms
// - emergency stop overrides all, no restart
// - category 0 cuts now, category 1 later
`timescale 1ns/1ps
`include "srcm_regs.svh"
module srcm_drive #(
	parameter int MISMATCH_CYC = `SRCM_MISMATCH_CYC,
	parameter int RELEASE_CYC = `SRCM_RELEASE_CYC,
	parameter int INPUT_CYC = `SRCM_INPUT_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	srcm_if.drive lnk,
	input wire logic [5:0] i_pwm,
	input wire logic i_move_cmd,
	output logic [5:0] o_gate,
	output logic o_safety_relay_first,
	output logic o_safety_relay_second,
	output logic o_ctrl_active,
	output logic o_fault,
	output logic [1:0] o_err
);
	typedef struct packed {
		logic [1:0] sup1;
		logic [1:0] sup2;
		logic [1:0] en;
		logic [1:0] clr;
		logic [31:0] rel1_cnt;
		logic [31:0] rel2_cnt;
		logic relay1;
		logic relay2;
		logic [31:0] in_cnt;
		logic aux1;
		logic aux2;
		logic [31:0] mis_cnt;
		logic fault;
		srcm_pkg::srcm_err_e err;
		logic active;
		logic [5:0] gate;
		logic moved;
	} srcm_drv_s;
	srcm_drv_s q, d;

	always_comb begin
		d = q;
		d.sup1 = {q.sup1[0], lnk.relay_first_supply};
		d.sup2 = {q.sup2[0], lnk.relay_second_supply};
		d.en = {q.en[0], lnk.ctrl_enable};
		d.clr = {q.clr[0], lnk.fault_clear};
		// relays drop after release time, pick up at once
		if (q.sup1[1]) begin
			d.relay1 = 1'b1;
			d.rel1_cnt = '0;
		end else if (q.rel1_cnt >= 32'(RELEASE_CYC - 1)) begin
			d.relay1 = 1'b0;
		end else begin
			d.rel1_cnt = q.rel1_cnt + 32'h1;
		end
		if (q.sup2[1]) begin
			d.relay2 = 1'b1;
			d.rel2_cnt = '0;
		end else if (q.rel2_cnt >= 32'(RELEASE_CYC - 1)) begin
			d.relay2 = 1'b0;
		end else begin
			d.rel2_cnt = q.rel2_cnt + 32'h1;
		end
		// contact input stage delay, bounded
		if (q.in_cnt >= 32'(INPUT_CYC - 1)) begin
			d.in_cnt = '0;
			d.aux1 = q.relay1;
			d.aux2 = q.relay2;
		end else begin
			d.in_cnt = q.in_cnt + 32'h1;
		end
		if (q.aux1 == q.aux2) begin
			d.mis_cnt = '0;
		end else if (q.mis_cnt < 32'(MISMATCH_CYC)) begin
			d.mis_cnt = q.mis_cnt + 32'h1;
		end
		if (q.clr[1] && !q.en[1]) begin
			d.fault = 1'b0;
			d.err = srcm_pkg::SRCM_ERR_NONE;
		end
		if (q.mis_cnt >= 32'(MISMATCH_CYC)) begin
			d.fault = 1'b1;
			d.err = srcm_pkg::SRCM_ERR_MISMATCH;
		end else if (q.en[1] && !(q.relay1 && q.relay2)) begin
			d.fault = 1'b1;
			d.err = srcm_pkg::SRCM_ERR_ENABLE;
		end
		d.active = q.en[1] && !d.fault;
		// upper switches need relay one, lower need relay two
		d.gate[2:0] = (q.active && q.relay1) ? i_pwm[2:0] : 3'h0;
		d.gate[5:3] = (q.active && q.relay2) ? i_pwm[5:3] : 3'h0;
		d.moved = i_move_cmd && (|q.gate);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_gate = q.gate;
	assign o_safety_relay_first = q.relay1;
	assign o_safety_relay_second = q.relay2;
	assign o_ctrl_active = q.active;
	assign o_fault = q.fault;
	assign o_err = q.err;
	assign lnk.aux_contact_first = q.aux1;
	assign lnk.aux_contact_second = q.aux2;
	assign lnk.drive_fault = q.fault;
	assign lnk.drive_err = q.err;
	assign lnk.motor_moved = q.moved;
	assign lnk.contactor_open = q.fault;
endmodule : srcm_drive

/* File: design/srcm_fieldbus.sv */
// fieldbus end: supervisor with release test and avalon registers
//
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "srcm_regs.svh"
module srcm_fieldbus #(
	parameter int SETTLE_CYC = `SRCM_SETTLE_CYC
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	srcm_if.fieldbus lnk,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic o_contactor_on,
	output logic o_irq
);
	typedef struct packed {
		logic [4:0] ctrl;
		logic [1:0] aux1;
		logic [1:0] aux2;
		logic [1:0] dflt;
		logic [1:0] mov;
		srcm_pkg::srcm_test_e st;
		logic [15:0] cnt;
		logic defect;
		logic passed;
		logic [`SRCM_EV_WIDTH-1:0] ist;
		logic [`SRCM_EV_WIDTH-1:0] ien;
		logic r1;
		logic r2;
		logic en;
		logic contactor;
		logic [31:0] rdata;
		logic ack;
		logic irq;
	} srcm_fb_s;
	srcm_fb_s q, d;
	logic [`SRCM_EV_WIDTH-1:0] ev;
	logic bad;
	logic req;

	always_comb begin
		d = q;
		ev = '0;
		req = (i_avs_read || i_avs_write) && !q.ack;
		d.aux1 = {q.aux1[0], lnk.aux_contact_first};
		d.aux2 = {q.aux2[0], lnk.aux_contact_second};
		d.dflt = {q.dflt[0], lnk.drive_fault};
		d.mov = {q.mov[0], lnk.motor_moved};
		bad = 1'b0;
		d.cnt = q.cnt + 16'h1;
		unique case (q.st)
			srcm_pkg::SRCM_T_IDLE: begin
				d.cnt = '0;
				if (q.ctrl[`SRCM_CTRL_TEST_BIT] && !q.ctrl[`SRCM_CTRL_ESTOP_BIT]) begin
					d.st = srcm_pkg::SRCM_T_BOTH_OFF;
					d.defect = 1'b0;
					d.passed = 1'b0;
				end
			end
			srcm_pkg::SRCM_T_BOTH_OFF,
			srcm_pkg::SRCM_T_FIRST_ON,
			srcm_pkg::SRCM_T_SECOND_ON: begin
				d.r1 = (q.st == srcm_pkg::SRCM_T_FIRST_ON);
				d.r2 = (q.st == srcm_pkg::SRCM_T_SECOND_ON);
				d.en = 1'b1;
				if (q.cnt == 16'(SETTLE_CYC)) begin
					bad = q.mov[1] || q.aux1[1] != q.r1 ||
						q.aux2[1] != q.r2;
					d.cnt = '0;
					d.en = 1'b0;
					if (bad) begin
						d.defect = 1'b1;
						d.st = srcm_pkg::SRCM_T_DONE;
						ev[`SRCM_EV_DEFECT] = 1'b1;
					end else if (q.st == srcm_pkg::SRCM_T_SECOND_ON) begin
						d.passed = 1'b1;
						d.st = srcm_pkg::SRCM_T_DONE;
						ev[`SRCM_EV_PASS] = 1'b1;
					end else begin
						d.st = (q.st == srcm_pkg::SRCM_T_BOTH_OFF) ?
							srcm_pkg::SRCM_T_FIRST_ON : srcm_pkg::SRCM_T_SECOND_ON;
					end
				end
			end
			srcm_pkg::SRCM_T_DONE: begin
				d.r1 = 1'b0;
				d.r2 = 1'b0;
				d.en = 1'b0;
				if (!q.ctrl[`SRCM_CTRL_TEST_BIT]) begin
					d.st = srcm_pkg::SRCM_T_IDLE;
				end
			end
			default: d.st = srcm_pkg::SRCM_T_IDLE;
		endcase
		if (q.st == srcm_pkg::SRCM_T_IDLE) begin
			d.r1 = q.ctrl[`SRCM_CTRL_EN_BIT];
			d.r2 = q.ctrl[`SRCM_CTRL_EN_BIT];
			// enable only once both contacts confirm the relays
			d.en = q.ctrl[`SRCM_CTRL_EN_BIT] && !q.defect &&
				q.aux1[1] && q.aux2[1];
		end
		// plausibility in normal run: the two contacts must agree and the drive must report no fault
		if (q.st == srcm_pkg::SRCM_T_IDLE && (q.aux1[1] != q.aux2[1] ||
			q.dflt[1])) begin
			ev[`SRCM_EV_FAULT] = 1'b1;
		end
		d.contactor = !(q.defect || q.dflt[1] || ev[`SRCM_EV_FAULT] ||
			q.ctrl[`SRCM_CTRL_ESTOP_BIT] && !q.ctrl[`SRCM_CTRL_CAT1_BIT]);
		if (q.ctrl[`SRCM_CTRL_ESTOP_BIT]) begin
			d.en = 1'b0;
			d.r1 = 1'b0;
			d.r2 = 1'b0;
			d.ctrl[`SRCM_CTRL_EN_BIT] = 1'b0;
			if (q.ctrl[`SRCM_CTRL_CAT1_BIT] && !q.mov[1]) begin
				d.contactor = 1'b0;
			end
		end
		d.ack = req;
		if (req && i_avs_write) begin
			unique case (i_avs_address)
				`SRCM_REG_CTRL: d.ctrl = i_avs_writedata[4:0];
				`SRCM_REG_IRQ_CLR: d.ist = q.ist & ~i_avs_writedata[2:0];
				default: ;
			endcase
			if (i_avs_address == `SRCM_REG_STAT) begin
				d.ien = i_avs_writedata[2:0];
			end
		end
		if (req && i_avs_read) begin
			unique case (i_avs_address)
				`SRCM_REG_CTRL: d.rdata = {27'h0, q.ctrl};
				`SRCM_REG_STAT: d.rdata = {16'h0, 5'h0, q.st, q.passed,
					q.defect, q.dflt[1], q.aux2[1], q.aux1[1], q.ien};
				`SRCM_REG_IRQ_STAT: d.rdata = {29'h0, q.ist};
				default: d.rdata = 32'h0;
			endcase
		end
		d.ist = d.ist | ev;
		d.irq = |(d.ist & d.ien);
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign o_avs_readdata = q.rdata;
	assign o_avs_waitrequest = !q.ack;
	assign o_contactor_on = q.contactor;
	assign o_irq = q.irq;
	assign lnk.relay_first_supply = q.r1;
	assign lnk.relay_second_supply = q.r2;
	assign lnk.ctrl_enable = q.en;
	assign lnk.fault_clear = q.ctrl[`SRCM_CTRL_CLR_BIT];
endmodule : srcm_fieldbus

/* File: sim/srcm_link_properties.sv */
// assertions on the drive to fieldbus link signals
`timescale 1ns/1ps
module srcm_link_chk #(
	parameter int MISMATCH_CYC = 40
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic relay_first_supply,
	input wire logic relay_second_supply,
	input wire logic ctrl_enable,
	input wire logic fault_clear,
	input wire logic aux_contact_first,
	input wire logic aux_contact_second,
	input wire logic drive_fault,
	input wire logic [1:0] drive_err,
	input wire logic motor_moved,
	input wire logic contactor_open,
	input wire logic contactor_on
);
	logic [7:0] mis_q;
	logic [3:0] clr_q;
	// run of contact disagreement, and age of the last fault clear
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mis_q <= 8'h00;
			clr_q <= 4'hf;
		end else begin
			if (aux_contact_first == aux_contact_second)
				mis_q <= 8'h00;
			else if (mis_q != 8'hff)
				mis_q <= mis_q + 8'h01;
			if (fault_clear && !ctrl_enable)
				clr_q <= 4'h0;
			else if (clr_q != 4'hf)
				clr_q <= clr_q + 4'h1;
		end
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);
	sequence first_off;
		!relay_first_supply [*8];
	endsequence
	sequence second_off;
		!relay_second_supply [*8];
	endsequence
	sequence enabled_dark;
		(ctrl_enable && !aux_contact_first && !aux_contact_second) [*4];
	endsequence
	mismatch_trip_a: assert property (
		mis_q > MISMATCH_CYC + 4 |-> drive_fault)
		else $error("mismatch held without fault");
	timer_restart_a: assert property (
		$rose(drive_fault) && drive_err == srcm_pkg::SRCM_ERR_MISMATCH
		|-> mis_q >= MISMATCH_CYC - 4)
		else $error("mismatch fault before the window ran out");
	enable_dark_a: assert property (
		enabled_dark |-> ##[0:8] drive_fault)
		else $error("enable without relay gave no fault");
	fault_sticky_a: assert property (
		$fell(drive_fault) |-> clr_q < 4'h8)
		else $error("fault dropped without a clear");
	fault_code_a: assert property (
		drive_fault |-> drive_err != srcm_pkg::SRCM_ERR_NONE)
		else $error("fault without error code");
	energy_cut_a: assert property (
		drive_fault |-> contactor_open ##[0:4] !contactor_on)
		else $error("fault did not open contactor");
	first_release_a: assert property (
		first_off |-> !aux_contact_first)
		else $error("first relay stayed on");
	second_release_a: assert property (
		second_off |-> !aux_contact_second)
		else $error("second relay stayed on");
endmodule : srcm_link_chk

/* File: sim/srcm_tb_top.sv */
// bench: both ends joined, plus a drive end fed by the bench
`timescale 1ns/1ps
module safety_relay_contact_monitor_tb_top;
	localparam int MIS = 40;
	typedef struct {
		logic [3:0] a;
		logic w;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} srcm_row_s;
	srcm_row_s rows [6] = '{
		'{4'h4, 1'b1, 32'h7, 32'h0, 32'h0},
		'{4'h4, 1'b0, 32'h0, 32'h7, 32'h7},
		'{4'h4, 1'b1, 32'h0, 32'h0, 32'h0},
		'{4'h2, 1'b1, 32'hffffffff, 32'h0, 32'h0},
		'{4'h4, 1'b0, 32'h0, 32'h7, 32'h0},
		'{4'h2, 1'b0, 32'h0, 32'hffffffff, 32'h0}
	};
	logic i_clk, i_reset_n, rd, wr, wait_r, irq, r1, r2, act, flt;
	logic con, mv;
	logic [3:0] adr;
	logic [31:0] wd, rdata, q;
	logic [5:0] p2, g2;
	logic [1:0] err;
	int error_cnt = 0;
	int cmp_count = 0;
	srcm_if lnk1 ();
	srcm_if lnk2 ();
	srcm_drive #(.MISMATCH_CYC(MIS), .RELEASE_CYC(2), .INPUT_CYC(1))
		srcm_drive_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .lnk(lnk1),
		.i_pwm(p2), .i_move_cmd(mv), .o_gate(),
		.o_safety_relay_first(), .o_safety_relay_second(),
		.o_ctrl_active(), .o_fault(), .o_err());
	srcm_drive #(.MISMATCH_CYC(MIS), .RELEASE_CYC(2), .INPUT_CYC(1))
		srcm_drive2_inst (.i_clk(i_clk), .i_reset_n(i_reset_n), .lnk(lnk2),
		.i_pwm(p2), .i_move_cmd(mv), .o_gate(g2),
		.o_safety_relay_first(r1), .o_safety_relay_second(r2),
		.o_ctrl_active(act), .o_fault(flt), .o_err(err));
	srcm_fieldbus #(.SETTLE_CYC(60)) srcm_fieldbus_inst (.i_clk(i_clk),
		.i_reset_n(i_reset_n), .lnk(lnk1), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_r),
		.o_contactor_on(con), .o_irq(irq));
	srcm_link_chk #(.MISMATCH_CYC(MIS)) srcm_link_chk_inst (.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.relay_first_supply(lnk1.relay_first_supply),
		.relay_second_supply(lnk1.relay_second_supply),
		.ctrl_enable(lnk1.ctrl_enable), .fault_clear(lnk1.fault_clear),
		.aux_contact_first(lnk1.aux_contact_first),
		.aux_contact_second(lnk1.aux_contact_second),
		.drive_fault(lnk1.drive_fault), .drive_err(lnk1.drive_err),
		.motor_moved(lnk1.motor_moved),
		.contactor_open(lnk1.contactor_open), .contactor_on(con));
	task automatic end_of_test;
		if (error_cnt == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic chk(input string nm, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected %s exp %h seen %h", nm, e, s);
		end
	endtask : chk
	// entered just after an edge; holds the request until waitrequest low
	task automatic bus(input logic [3:0] a, input logic w,
		input logic [31:0] d);
		adr <= a;
		rd <= !w;
		wr <= w;
		wd <= d;
		// only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge i_clk);
		end while (wait_r !== 1'b0);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge i_clk);
	endtask : bus
	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end
	initial begin
		#8000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{i_reset_n, rd, wr, adr, wd, p2} = '0;
		mv = 1'b1;
		{lnk2.relay_first_supply, lnk2.relay_second_supply} = 2'b00;
		{lnk2.ctrl_enable, lnk2.fault_clear} = 2'b00;
		repeat (10) @(posedge i_clk);
		chk("waitrequest", wait_r, 1'b1);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		foreach (rows[i]) begin
			bus(rows[i].a, rows[i].w, rows[i].d);
			chk("readdata", q & rows[i].m, rows[i].e);
		end
		bus(4'h4, 1'b1, 32'h4);
		bus(4'h0, 1'b1, 32'h1);
		for (int k = 0; k < 200 && q[2] !== 1'b1; k++)
			bus(4'h8, 1'b0, 32'h0);
		chk("test_pass", q[2], 1'b1);
		chk("defect", q[0], 1'b0);
		chk("irq_set", irq, 1'b1);
		bus(4'hc, 1'b1, 32'h4);
		chk("irq_clr", irq, 1'b0);
		chk("fault_cut", con, 1'b0);
		bus(4'h0, 1'b1, 32'h2);
		repeat (10) @(posedge i_clk);
		chk("clear_on", con, 1'b1);
		bus(4'h0, 1'b1, 32'hc);
		bus(4'h0, 1'b0, 32'h0);
		chk("estop_en", q[4:0], 5'h08);
		chk("estop_cut", con, 1'b0);
		// relays first, enable once they have picked up
		lnk2.relay_first_supply <= 1'b1;
		lnk2.relay_second_supply <= 1'b1;
		p2 <= 6'h2d;
		repeat (6) @(posedge i_clk);
		lnk2.ctrl_enable <= 1'b1;
		repeat (12) @(posedge i_clk);
		chk("gates", g2, 6'h2d);
		chk("relays_on", {r1, r2}, 2'b11);
		chk("moved", lnk2.motor_moved, 1'b1);
		mv <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("still", lnk2.motor_moved, 1'b0);
		lnk2.relay_first_supply <= 1'b0;
		repeat (12) @(posedge i_clk);
		chk("upper", g2[2:0], 3'h0);
		chk("err_en", {flt, err}, {1'b1, srcm_pkg::SRCM_ERR_ENABLE});
		lnk2.relay_second_supply <= 1'b0;
		lnk2.ctrl_enable <= 1'b0;
		lnk2.fault_clear <= 1'b1;
		repeat (8) @(posedge i_clk);
		lnk2.fault_clear <= 1'b0;
		lnk2.relay_first_supply <= 1'b1;
		repeat (30) @(posedge i_clk);
		chk("short", flt, 1'b0);
		lnk2.relay_second_supply <= 1'b1;
		repeat (10) @(posedge i_clk);
		lnk2.relay_second_supply <= 1'b0;
		repeat (30) @(posedge i_clk);
		chk("restart", flt, 1'b0);
		repeat (30) @(posedge i_clk);
		chk("err_mis", {flt, err}, {1'b1, srcm_pkg::SRCM_ERR_MISMATCH});
		chk("active", act, 1'b0);
		chk("relays", {r1, r2}, 2'b10);
		// reset again in mid-run
		i_reset_n <= 1'b0;
		repeat (2) @(posedge i_clk);
		chk("rst_out", {wait_r, flt, act, con, irq, g2}, 11'h400);
		i_reset_n <= 1'b1;
		repeat (4) @(posedge i_clk);
		chk("rst_on", con, 1'b1);
		bus(4'h4, 1'b0, 32'h0);
		chk("rst_stat", q[6:0], 7'h00);
		end_of_test();
	end
endmodule : safety_relay_contact_monitor_tb_top
